// [bench/adtc_trig_src.sv]
/* Model of the on-chip hardware trigger sources.
   Assumes the bench raises fire just after a clk edge for one cycle. */
module adtc_trig_src (
   // command from the bench
   input wire logic fire,
   input wire adtc_pkg::adtc_src_t fire_sel,
   // trigger pulses towards the block
   output logic timer_channel_irq,
   output logic calendar_irq,
   output logic interval_timer_irq
);
   timeunit 1ns;
   timeprecision 1ns;
   import adtc_pkg::*;
   // code 01 has no source behind it, so it can never pulse
   assign timer_channel_irq = fire && fire_sel == ADTC_SRC_TIMER;
   assign calendar_irq = fire && fire_sel == ADTC_SRC_CALENDAR;
   assign interval_timer_irq = fire && fire_sel == ADTC_SRC_INTERVAL;
endmodule : adtc_trig_src

// [bench/tb_adtc_top.sv]
/* Self-checking bench for the converter timing and trigger control.
   Assumes the design files and adtc_defines.svh are compiled first. */
`include "adtc_defines.svh"

module tb_adtc_top;
   timeunit 1ns;
   timeprecision 1ns;
   import adtc_pkg::*;
   logic clk, rstn, reg_wr, reg_bit_wr, reg_rd, fire;
   logic [19:0] reg_addr;
   logic [2:0] reg_bit_idx, clock_divider_sel;
   logic [7:0] reg_wdata, reg_rdata;
   adtc_timing_t timing_mode_sel;
   adtc_src_t fire_sel;
   logic comparator_enable, scan_mode, res_8bit;
   logic run_wr_one, run_wr_zero, channel_select_reg_wr;
   logic timer_channel_irq, calendar_irq, interval_timer_irq;
   logic conversion_run, conversion_done_irq, sampling;
   logic [1:0] scan_channel;
   int fails, n_checks, samp_w, samp_cnt, n, i, j, r, e;
   int ratio_tab [8] = '{64, 32, 16, 8, 6, 5, 4, 2};

   adtc_top adtc_top_inst (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_bit_wr(reg_bit_wr), .reg_bit_idx(reg_bit_idx),
      .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .clock_divider_sel(clock_divider_sel),
      .timing_mode_sel(timing_mode_sel),
      .comparator_enable(comparator_enable), .scan_mode(scan_mode),
      .res_8bit(res_8bit), .run_wr_one(run_wr_one),
      .run_wr_zero(run_wr_zero),
      .channel_select_reg_wr(channel_select_reg_wr),
      .timer_channel_irq(timer_channel_irq), .calendar_irq(calendar_irq),
      .interval_timer_irq(interval_timer_irq),
      .conversion_run(conversion_run),
      .conversion_done_irq(conversion_done_irq), .sampling(sampling),
      .scan_channel(scan_channel));

   adtc_trig_src adtc_trig_src_inst (.fire(fire), .fire_sel(fire_sel),
      .timer_channel_irq(timer_channel_irq), .calendar_irq(calendar_irq),
      .interval_timer_irq(interval_timer_irq));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // width of the last sampling phase in system clocks
   always @(posedge clk) begin
      if (sampling === 1'b1) begin
         samp_cnt <= samp_cnt + 1;
      end else if (samp_cnt != 0) begin
         samp_w <= samp_cnt;
         samp_cnt <= 0;
      end
   end

   task automatic close_out();
      $display("checks %0d fails %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : close_out

   task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
      n_checks++;
      if (exp !== got) begin
         fails++;
         $display("wrong value %s exp %0h seen %0h", what, exp, got);
      end
   endtask : chk

   task automatic rng(string what, int lo, int hi, int got);
      n_checks++;
      if (got < lo || got > hi) begin
         fails++;
         $display("wrong value %s exp %0d..%0d seen %0d", what, lo, hi, got);
      end
   endtask : rng

   task automatic step();
      @(posedge clk);
      #1;
   endtask : step

   task automatic rd(logic [19:0] a, logic [7:0] exp);
      reg_addr = a;
      reg_rd = 1'b1;
      step();
      chk("rdata", exp, reg_rdata);
      reg_rd = 1'b0;
      step();
   endtask : rd

   task automatic wr(logic [7:0] d);
      reg_addr = `ADTC_TRIG_CFG_ADDR;
      reg_wdata = d;
      reg_wr = 1'b1;
      step();
      reg_wr = 1'b0;
      step();
   endtask : wr

   task automatic wrbit(logic [2:0] idx, logic v);
      reg_addr = `ADTC_TRIG_CFG_ADDR;
      reg_bit_idx = idx;
      reg_wdata = {7'h00, v};
      reg_bit_wr = 1'b1;
      step();
      reg_bit_wr = 1'b0;
      step();
   endtask : wrbit

   // mode bits move only with run and enable low, enable before run
   task automatic setup(logic [7:0] cfg, logic [2:0] sel, adtc_timing_t tm,
                        logic r8, logic sc);
      comparator_enable = 1'b0;
      step();
      clock_divider_sel = sel;
      timing_mode_sel = tm;
      res_8bit = r8;
      scan_mode = sc;
      wr(cfg);
      comparator_enable = 1'b1;
      step();
   endtask : setup

   task automatic run1();
      run_wr_one = 1'b1;
      step();
      run_wr_one = 1'b0;
   endtask : run1

   task automatic run0();
      run_wr_zero = 1'b1;
      step();
      run_wr_zero = 1'b0;
      step();
   endtask : run0

   task automatic fire_src(adtc_src_t s);
      fire_sel = s;
      fire = 1'b1;
      step();
      fire = 1'b0;
      step();
   endtask : fire_src

   task automatic wait_done(output int c);
      c = 0;
      do begin
         step();
         c++;
      end while (conversion_done_irq !== 1'b1 && c < 4000);
      if (c >= 4000) begin
         fails++;
         $display("wrong value done exp pulse seen none");
         close_out();
      end
   endtask : wait_done

   task automatic no_done(int cyc);
      int hits;
      hits = 0;
      repeat (cyc) begin
         step();
         if (conversion_done_irq !== 1'b0) hits++;
      end
      chk("stray done", 0, hits);
   endtask : no_done

   initial begin
      {rstn, reg_wr, reg_bit_wr, reg_rd, fire, reg_addr} = '0;
      {reg_bit_idx, clock_divider_sel, reg_wdata} = '0;
      {comparator_enable, scan_mode, res_8bit} = '0;
      {run_wr_one, run_wr_zero, channel_select_reg_wr} = '0;
      timing_mode_sel = ADTC_NORMAL1;
      fire_sel = ADTC_SRC_TIMER;
      {fails, n_checks, samp_w, samp_cnt} = '0;
      repeat (16) @(posedge clk);
      #1;
      rstn = 1'b1;
      repeat (3) step();
      rd(`ADTC_TRIG_CFG_ADDR, 8'h00);
      wr(8'hff);
      rd(`ADTC_TRIG_CFG_ADDR, 8'he3);
      rd(20'hfff33, 8'h00);
      wrbit(3'h5, 1'b0);
      wrbit(3'h3, 1'b1);
      rd(`ADTC_TRIG_CFG_ADDR, 8'hc3);
      wrbit(3'h6, 1'b0);
      rd(`ADTC_TRIG_CFG_ADDR, 8'h83);
      for (i = 0; i < 8; i++) begin
         r = ratio_tab[i];
         setup(8'h20, i[2:0], ADTC_NORMAL1, 1'b0, 1'b0);
         run1();
         wait_done(n);
         rng("sw time", 20 * r - 1, 20 * r + 2, n);
         chk("sample width", 7 * r, samp_w);
         step();
         step();
         chk("run after one shot", 0, conversion_run);
      end
      // each timing mode at divide by 8, plus 8-bit resolution
      for (j = 0; j < 5; j++) begin
         setup(8'h20, 3'h3, adtc_timing_t'(j[1:0]), j == 4, 1'b0);
         e = ((j[0] ? 17 : 19) - (j == 4 ? 2 : 0) + 1) * 8;
         run1();
         wait_done(n);
         rng("mode time", e - 1, e + 2, n);
         chk("mode sample", (j[0] ? 5 : 7) * 8, samp_w);
      end
      setup(8'h00, 3'h3, ADTC_NORMAL1, 1'b0, 1'b0);
      run1();
      wait_done(n);
      wait_done(n);
      rng("seq gap", 151, 153, n);
      repeat (20) step();
      channel_select_reg_wr = 1'b1;
      step();
      channel_select_reg_wr = 1'b0;
      wait_done(n);
      rng("restart time", 159, 162, n);
      run0();
      chk("run after stop", 0, conversion_run);
      no_done(200);
      setup(8'h20, 3'h3, ADTC_NORMAL1, 1'b0, 1'b1);
      run1();
      wait_done(n);
      wait_done(n);
      rng("scan gap", 151, 153, n);
      chk("scan channel", 2, scan_channel);
      wait_done(n);
      wait_done(n);
      step();
      step();
      chk("run after scan", 0, conversion_run);
      no_done(200);
      // wait mode: start delay of one clock, then stabilisation
      for (j = 0; j < 2; j++) begin
         setup(8'he0, 3'h3, j ? ADTC_LOWV1 : ADTC_NORMAL1, 1'b0, 1'b0);
         e = ((j ? 2 : 8) + 19) * 8 + 2;
         fire_src(ADTC_SRC_TIMER);
         chk("run on trigger", 1, conversion_run);
         wait_done(n);
         rng("wait time", e - 2, e + 2, n + 1);
      end
      for (j = 0; j < 4; j++) begin
         if (j != 1) begin
            setup(8'ha0 | j[7:0], 3'h3, ADTC_NORMAL1, 1'b0, 1'b0);
            run1();
            for (i = 0; i < 4; i++) begin
               if (i != 1 && i != j) fire_src(adtc_src_t'(i[1:0]));
            end
            no_done(30);
            fire_src(adtc_src_t'(j[1:0]));
            wait_done(n);
            rng("hw time", 158, 161, n);
            step();
            chk("run kept", 1, conversion_run);
            run0();
         end
      end
      setup(8'he1, 3'h3, ADTC_NORMAL1, 1'b0, 1'b0);
      run1();
      fire_src(ADTC_SRC_TIMER);
      fire_src(ADTC_SRC_CALENDAR);
      fire_src(ADTC_SRC_INTERVAL);
      no_done(200);
      run0();
      close_out();
   end
endmodule : tb_adtc_top

// [hw/adtc_clk_div.sv]
/*
 * Conversion clock divider: one-cycle enable every ratio system clocks.
 * Assumes a synchronised active-low reset and ratio of 2 or more.
 */
module adtc_clk_div #(
   parameter int CW = 7
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // control
   input wire logic restart,
   input wire logic [CW-1:0] ratio,
   // conversion clock enable
   output logic tick
);
   import adtc_pkg::*;

   logic [CW-1:0] cnt_ff;
   logic [CW-1:0] nxt_cnt;
   logic last;

   // restart aligns the first tick a full period after the start delay
   assign last = (cnt_ff == ratio - CW'(1));
   assign tick = last && !restart;

   always_comb begin
      if (restart || last) begin
         nxt_cnt = '0;
      end else begin
         nxt_cnt = cnt_ff + CW'(1);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_ff <= '0;
      end else begin
         cnt_ff <= nxt_cnt;
      end
   end

endmodule : adtc_clk_div

// [hw/adtc_defines.svh]
/*
 * Offsets, field positions, reset values and cycle counts of the
 * converter timing and trigger control.
 * Assumes inclusion by bare name from every file that uses it.
 */
`ifndef ADTC_DEFINES_SVH
`define ADTC_DEFINES_SVH

`define ADTC_TRIG_CFG_ADDR 20'hfff32
`define ADTC_TRIG_CFG_RESET 8'h00
`define ADTC_TRIG_CFG_MASK 8'he3
`define ADTC_TMODE_HI 7
`define ADTC_TMODE_LO 6
`define ADTC_ONE_SHOT 5
`define ADTC_TSRC_HI 1
`define ADTC_TSRC_LO 0

`define ADTC_CONV_MODE1 5'h13
`define ADTC_SAMP_MODE1 5'h07
`define ADTC_CONV_MODE2 5'h11
`define ADTC_SAMP_MODE2 5'h05
`define ADTC_RES8_SHORTEN 5'h02
`define ADTC_STAB_NORMAL 5'h08
`define ADTC_STAB_LOWV 5'h02
`define ADTC_WAIT_START 8'h01
`define ADTC_SCAN_LAST 2'h3

`endif

// [hw/adtc_pkg.sv]
/*
 * Types shared by the converter timing and trigger control.
 * Assumes nothing of its surroundings.
 */
package adtc_pkg;

   typedef enum logic [5:0] {
      ADTC_ST_IDLE = 6'h01,
      ADTC_ST_START = 6'h02,
      ADTC_ST_STAB = 6'h04,
      ADTC_ST_SAMPLE = 6'h08,
      ADTC_ST_CONV = 6'h10,
      ADTC_ST_WAIT_TRIG = 6'h20
   } adtc_state_t;

   typedef enum logic [1:0] {
      ADTC_NORMAL1 = 2'h0,
      ADTC_NORMAL2 = 2'h1,
      ADTC_LOWV1 = 2'h2,
      ADTC_LOWV2 = 2'h3
   } adtc_timing_t;

   typedef enum logic [1:0] {
      ADTC_SRC_TIMER = 2'h0,
      ADTC_SRC_NONE = 2'h1,
      ADTC_SRC_CALENDAR = 2'h2,
      ADTC_SRC_INTERVAL = 2'h3
   } adtc_src_t;

endpackage : adtc_pkg

// [hw/adtc_top.sv]
/*
 * Converter timing and trigger control: divider, trigger selection,
 * start delay, stabilisation wait, sampling and conversion phases.
 * Assumes mode bits come from logic on clk and the hardware trigger
 * sources are one-cycle pulses on clk; rstn may be asynchronous.
 */
// What this block does
// - conversion clock is system clock divided by 64,32,16,8,6,5,4,2 per select
// - modes: normal1/2, low-voltage1/2; mode1 19 cycles/7 sampling, mode2 17/5
// - hardware wait mode inserts 8 (normal) or 2 (low-voltage) stabilisation ticks
// - wait mode total equals divider ratio times stabilisation plus conversion
// - eight-bit resolution shortens each conversion by two conversion clocks
// - first conversion after a start gets the conversion start delay
// - later sequential or scan 1-3 conversions skip start delay and wait
// - software mode starts on run write or channel rewrite; done pulses
// - trigger config: mode 7:6, one-shot 5, source 1:0, bits 4:2 zero
// - trigger config accepts single-bit and whole-byte writes
// - reset clears trigger config to zero, software trigger mode
// - mode 0x software, 10 hardware no-wait, 11 hardware with wait
// - run and enable: 00 stop, 01 standby, 11 converting, 10 prohibited
// - trigger source: 00 timer, 10 calendar, 11 interval, 01 prohibited
`include "adtc_defines.svh"

module adtc_top (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // cpu register port
   input wire logic [19:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_bit_wr,
   input wire logic [2:0] reg_bit_idx,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // mode bits held elsewhere
   input wire logic [2:0] clock_divider_sel,
   input wire adtc_pkg::adtc_timing_t timing_mode_sel,
   input wire logic comparator_enable,
   input wire logic scan_mode,
   input wire logic res_8bit,
   // run bit and channel register writes
   input wire logic run_wr_one,
   input wire logic run_wr_zero,
   input wire logic channel_select_reg_wr,
   // hardware trigger sources
   input wire logic timer_channel_irq,
   input wire logic calendar_irq,
   input wire logic interval_timer_irq,
   // status
   output logic conversion_run,
   output logic conversion_done_irq,
   output logic sampling,
   output logic [1:0] scan_channel
);
   import adtc_pkg::*;

   logic rst_meta_ff;
   logic rst_n;
   adtc_trig_if trig ();
   adtc_state_t st_ff, nxt_st;
   logic [7:0] cnt_ff, nxt_cnt;
   logic run_ff, nxt_run;
   logic done_ff, nxt_done;
   logic samp_ff, nxt_samp;
   logic [1:0] chan_ff, nxt_chan;
   logic [6:0] ratio;
   logic [4:0] conv_len, samp_len, stab_len;
   logic fad_tick, div_restart, hw_mode, hw_wait, trig_hit;
   logic last_conv;

   // reset release through two flops; assertion is immediate
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rst_meta_ff <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_n <= rst_meta_ff;
      end
   end

   adtc_trig_reg u_reg (
      .clk(clk),
      .rst_n(rst_n),
      .reg_addr(reg_addr),
      .reg_wr(reg_wr),
      .reg_bit_wr(reg_bit_wr),
      .reg_bit_idx(reg_bit_idx),
      .reg_wdata(reg_wdata),
      .reg_rd(reg_rd),
      .reg_rdata(reg_rdata),
      .cfg(trig.regs)
   );

   always_comb begin
      case (clock_divider_sel)
         3'h0: ratio = 7'h40;
         3'h1: ratio = 7'h20;
         3'h2: ratio = 7'h10;
         3'h3: ratio = 7'h08;
         3'h4: ratio = 7'h06;
         3'h5: ratio = 7'h05;
         3'h6: ratio = 7'h04;
         default: ratio = 7'h02;
      endcase
   end

   adtc_clk_div #(.CW(7)) u_div (
      .clk(clk),
      .rst_n(rst_n),
      .restart(div_restart),
      .ratio(ratio),
      .tick(fad_tick)
   );

   // mode 2 codes have bit 0 set, low-voltage codes bit 1
   assign samp_len = timing_mode_sel[0] ? `ADTC_SAMP_MODE2 :
                     `ADTC_SAMP_MODE1;
   assign conv_len = (timing_mode_sel[0] ? `ADTC_CONV_MODE2 :
                     `ADTC_CONV_MODE1) -
                     (res_8bit ? `ADTC_RES8_SHORTEN : 5'h00);
   assign stab_len = timing_mode_sel[1] ? `ADTC_STAB_LOWV :
                     `ADTC_STAB_NORMAL;

   assign hw_mode = trig.trigger_mode_sel[1];
   assign hw_wait = (trig.trigger_mode_sel == 2'h3);

   always_comb begin
      case (trig.trigger_source_sel)
         ADTC_SRC_TIMER: trig_hit = timer_channel_irq;
         ADTC_SRC_CALENDAR: trig_hit = calendar_irq;
         ADTC_SRC_INTERVAL: trig_hit = interval_timer_irq;
         default: trig_hit = 1'b0;
      endcase
   end

   assign last_conv = trig.one_shot_sel &&
                      (!scan_mode || chan_ff == `ADTC_SCAN_LAST);

   always_comb begin
      nxt_st = st_ff;
      nxt_cnt = cnt_ff;
      nxt_run = run_ff;
      nxt_chan = chan_ff;
      nxt_done = 1'b0;
      div_restart = 1'b0;
      if (run_wr_zero || !comparator_enable) begin
         // stopped or standby: nothing converts without the comparator
         nxt_st = ADTC_ST_IDLE;
         nxt_run = 1'b0;
         nxt_chan = 2'h0;
      end else if (!hw_mode && run_ff && channel_select_reg_wr) begin
         nxt_st = ADTC_ST_START;
         nxt_cnt = {1'b0, ratio - 7'h01};
         nxt_chan = 2'h0;
      end else begin
         case (st_ff)
            ADTC_ST_IDLE: begin
               nxt_chan = 2'h0;
               if (!hw_mode && run_wr_one) begin
                  nxt_run = 1'b1;
                  nxt_st = ADTC_ST_START;
                  nxt_cnt = {1'b0, ratio - 7'h01};
               end else if (hw_mode && !hw_wait && run_wr_one) begin
                  nxt_run = 1'b1;
                  nxt_st = ADTC_ST_WAIT_TRIG;
               end else if (hw_wait && trig_hit) begin
                  // run is set by the trigger itself in wait mode
                  nxt_run = 1'b1;
                  nxt_st = ADTC_ST_START;
                  nxt_cnt = `ADTC_WAIT_START;
               end
            end
            ADTC_ST_WAIT_TRIG: begin
               if (trig_hit) begin
                  nxt_st = ADTC_ST_START;
                  nxt_cnt = {1'b0, ratio - 7'h01};
               end
            end
            ADTC_ST_START: begin
               if (cnt_ff <= 8'h01) begin
                  div_restart = 1'b1;
                  nxt_cnt = 8'h00;
                  nxt_st = hw_wait ? ADTC_ST_STAB : ADTC_ST_SAMPLE;
               end else begin
                  nxt_cnt = cnt_ff - 8'h01;
               end
            end
            ADTC_ST_STAB: begin
               if (fad_tick) begin
                  if (cnt_ff == {3'h0, stab_len - 5'h01}) begin
                     nxt_st = ADTC_ST_SAMPLE;
                     nxt_cnt = 8'h00;
                  end else begin
                     nxt_cnt = cnt_ff + 8'h01;
                  end
               end
            end
            ADTC_ST_SAMPLE: begin
               if (fad_tick) begin
                  nxt_cnt = cnt_ff + 8'h01;
                  if (cnt_ff == {3'h0, samp_len - 5'h01}) begin
                     nxt_st = ADTC_ST_CONV;
                  end
               end
            end
            ADTC_ST_CONV: begin
               if (fad_tick) begin
                  nxt_cnt = cnt_ff + 8'h01;
                  if (cnt_ff == {3'h0, conv_len - 5'h01}) begin
                     nxt_done = 1'b1;
                     nxt_cnt = 8'h00;
                     nxt_chan = scan_mode ? chan_ff + 2'h1 : 2'h0;
                     if (!last_conv) begin
                        nxt_st = ADTC_ST_SAMPLE;
                     end else if (hw_mode && !hw_wait) begin
                        // no-wait one-shot keeps run set for next trigger
                        nxt_st = ADTC_ST_WAIT_TRIG;
                     end else begin
                        nxt_st = ADTC_ST_IDLE;
                        nxt_run = 1'b0;
                     end
                  end
               end
            end
            default: begin
               nxt_st = ADTC_ST_IDLE;
               nxt_run = 1'b0;
            end
         endcase
      end
      nxt_samp = (nxt_st == ADTC_ST_SAMPLE);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= ADTC_ST_IDLE;
         cnt_ff <= 8'h00;
         run_ff <= 1'b0;
         done_ff <= 1'b0;
         samp_ff <= 1'b0;
         chan_ff <= 2'h0;
      end else begin
         st_ff <= nxt_st;
         cnt_ff <= nxt_cnt;
         run_ff <= nxt_run;
         done_ff <= nxt_done;
         samp_ff <= nxt_samp;
         chan_ff <= nxt_chan;
      end
   end

   assign conversion_run = run_ff;
   assign conversion_done_irq = done_ff;
   assign sampling = samp_ff;
   assign scan_channel = chan_ff;

   // helper counters read only by the checks below
   logic [6:0] gap_ff, nxt_gap;
   logic [4:0] ph_ff, nxt_ph, tot_ff, nxt_tot;

   always_comb begin
      nxt_gap = (fad_tick || div_restart) ? 7'h00 : gap_ff + 7'h01;
      nxt_ph = (nxt_st != st_ff) ? 5'h00 : ph_ff + {4'h0, fad_tick};
      if (nxt_st == ADTC_ST_SAMPLE && st_ff != ADTC_ST_SAMPLE
          && st_ff != ADTC_ST_CONV) begin
         nxt_tot = 5'h00;
      end else if (done_ff) begin
         // hold the total through the done cycle, then start afresh
         nxt_tot = 5'h00;
      end else if (st_ff == ADTC_ST_SAMPLE || st_ff == ADTC_ST_CONV) begin
         nxt_tot = tot_ff + {4'h0, fad_tick};
      end else begin
         nxt_tot = tot_ff;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         gap_ff <= 7'h00;
         ph_ff <= 5'h00;
         tot_ff <= 5'h00;
      end else begin
         gap_ff <= nxt_gap;
         ph_ff <= nxt_ph;
         tot_ff <= nxt_tot;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_leave_stab;
      st_ff == ADTC_ST_STAB ##1 st_ff == ADTC_ST_SAMPLE;
   endsequence
   sequence s_enter_wait_start;
      st_ff != ADTC_ST_START ##1 st_ff == ADTC_ST_START && hw_wait;
   endsequence
   sequence s_continue;
      done_ff && run_ff && st_ff == ADTC_ST_SAMPLE;
   endsequence

   AST_DIV_RATIO: assert property (
      fad_tick && st_ff != ADTC_ST_IDLE |-> gap_ff == ratio - 7'h01)
      else $error("conversion clock period differs from divider ratio");

   AST_CONV_LEN: assert property (
      done_ff |-> tot_ff == (timing_mode_sel[0] ? 5'h11 : 5'h13)
                  - (res_8bit ? 5'h02 : 5'h00))
      else $error("conversion length wrong for mode or resolution");

   AST_SAMPLE_LEN: assert property (
      st_ff == ADTC_ST_SAMPLE ##1 st_ff == ADTC_ST_CONV
      |-> $past(ph_ff) == (timing_mode_sel[0] ? 5'h04 : 5'h06))
      else $error("sampling phase length wrong");

   AST_STAB_LEN: assert property (
      s_leave_stab |-> $past(ph_ff) == (timing_mode_sel[1] ? 5'h01 : 5'h07))
      else $error("stabilisation wait length wrong");

   AST_WAIT_START: assert property (
      s_enter_wait_start |=> st_ff == ADTC_ST_STAB)
      else $error("wait mode start delay not one cycle");

   AST_SKIP_DELAY: assert property (
      s_continue |-> $past(st_ff) == ADTC_ST_CONV)
      else $error("continued conversion passed start or wait");

   AST_DONE_PULSE: assert property (
      done_ff |=> !done_ff)
      else $error("completion interrupt longer than one cycle");

   AST_SW_START: assert property (
      st_ff == ADTC_ST_IDLE && comparator_enable && !run_wr_zero
      && !hw_mode && run_wr_one |=> st_ff == ADTC_ST_START ##[1:64]
      st_ff == ADTC_ST_SAMPLE)
      else $error("software start did not reach sampling");

   AST_NO_WAIT_STAB: assert property (
      !hw_wait |-> st_ff != ADTC_ST_STAB)
      else $error("stabilisation wait outside wait mode");

   AST_STANDBY: assert property (
      !comparator_enable |=> st_ff == ADTC_ST_IDLE && !run_ff)
      else $error("converting without comparator enabled");

   AST_BAD_SOURCE: assert property (
      trig.trigger_source_sel == ADTC_SRC_NONE && hw_wait
      && st_ff == ADTC_ST_IDLE |=> st_ff == ADTC_ST_IDLE)
      else $error("prohibited trigger source started a conversion");

endmodule : adtc_top

// [hw/adtc_trig_if.sv]
/*
 * Trigger configuration fields passed from the register to the core.
 * Assumes one producer (register) and one consumer (core).
 */
interface adtc_trig_if;
   logic [1:0] trigger_mode_sel;
   logic one_shot_sel;
   adtc_pkg::adtc_src_t trigger_source_sel;

   modport regs (
      output trigger_mode_sel,
      output one_shot_sel,
      output trigger_source_sel
   );
   modport core (
      input trigger_mode_sel,
      input one_shot_sel,
      input trigger_source_sel
   );
endinterface : adtc_trig_if

// [hw/adtc_trig_reg.sv]
/*
 * Trigger configuration register with bit and byte writes.
 * Assumes the CPU register port is synchronous to clk.
 */
`include "adtc_defines.svh"

module adtc_trig_reg (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // cpu register port
   input wire logic [19:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_bit_wr,
   input wire logic [2:0] reg_bit_idx,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // fields to the core
   adtc_trig_if.regs cfg
);
   import adtc_pkg::*;

   logic [7:0] cfg_ff;
   logic [7:0] nxt_cfg;
   logic [7:0] rdata_ff;
   logic [7:0] nxt_rdata;
   logic hit;

   assign hit = (reg_addr == `ADTC_TRIG_CFG_ADDR);

   always_comb begin
      nxt_cfg = cfg_ff;
      if (hit && reg_wr) begin
         nxt_cfg = reg_wdata & `ADTC_TRIG_CFG_MASK;
      end else if (hit && reg_bit_wr) begin
         nxt_cfg[reg_bit_idx] = reg_wdata[0];
         nxt_cfg = nxt_cfg & `ADTC_TRIG_CFG_MASK;
      end
      nxt_rdata = (hit && reg_rd) ? cfg_ff : 8'h00;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_ff <= `ADTC_TRIG_CFG_RESET;
         rdata_ff <= 8'h00;
      end else begin
         cfg_ff <= nxt_cfg;
         rdata_ff <= nxt_rdata;
      end
   end

   assign reg_rdata = rdata_ff;
   assign cfg.trigger_mode_sel = cfg_ff[`ADTC_TMODE_HI:`ADTC_TMODE_LO];
   assign cfg.one_shot_sel = cfg_ff[`ADTC_ONE_SHOT];
   assign cfg.trigger_source_sel =
      adtc_src_t'(cfg_ff[`ADTC_TSRC_HI:`ADTC_TSRC_LO]);

   AST_RESERVED_ZERO: assert property (
      @(posedge clk) disable iff (!rst_n)
      reg_rd && hit |=> reg_rdata[4:2] == 3'h0 && cfg_ff[4:2] == 3'h0)
      else $error("reserved trigger config bits not zero");

   AST_RESET_CLEAR: assert property (
      @(posedge clk) $rose(rst_n) |-> cfg_ff == 8'h00)
      else $error("trigger config not cleared by reset");

endmodule : adtc_trig_reg
